// ==== rtl/acv_cfg.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef ACV_CFG_SVH
`define ACV_CFG_SVH

// Register indices; the byte address is four times the index.
`define ACV_IDX_ICTL       8'h0b
`define ACV_IDX_PFLAGS     8'h0c
`define ACV_IDX_RES_HI     8'h1e
`define ACV_IDX_CTRL       8'h1f
`define ACV_IDX_PIE        8'h8c
`define ACV_IDX_PINSEL     8'h91
`define ACV_IDX_RES_LO     8'h9e
`define ACV_IDX_CLKSEL     8'h9f
`define ACV_IDX_IRQ_STAT   8'ha0
`define ACV_IDX_IRQ_MASK   8'ha1

// Reset values and masks of implemented bits.
`define ACV_RST_ICTL       8'h00
`define ACV_RST_PFLAGS     8'h00
`define ACV_RST_CTRL       8'h00
`define ACV_RST_PIE        8'h00
`define ACV_RST_PINSEL     8'hff
`define ACV_RST_CLKSEL     8'h00
`define ACV_MSK_FLAGS      8'hc9
`define ACV_MSK_CTRL       8'hdf
`define ACV_MSK_CLKSEL     8'h70

// Field positions.
`define ACV_BIT_GLOBAL_IE  7
`define ACV_BIT_PERIPH_IE  6
`define ACV_BIT_DONE       6
`define ACV_BIT_JUSTIFY    7
`define ACV_BIT_REF        6
`define ACV_BIT_GO         1
`define ACV_BIT_POWER      0
`define ACV_CHS_HI         4
`define ACV_CHS_LO         2
`define ACV_ADCS_HI        6
`define ACV_ADCS_LO        4

// Timing: core period, instruction cycle and internal oscillator period.
`define ACV_CLK_NS         25
`define ACV_INSTR_NS       100
`define ACV_RC_NS          4000
`define ACV_INSTR_CYC      (`ACV_INSTR_NS / `ACV_CLK_NS)
`define ACV_RC_CYC         (`ACV_RC_NS / `ACV_CLK_NS)

`endif

// ==== rtl/acv_pkg.sv ====
// Types shared by the converter control modules.
package acv_pkg;

  typedef enum logic [2:0] {
    ACV_IDLE  = 3'b001,
    ACV_DELAY = 3'b010,
    ACV_CONV  = 3'b100
  } acv_fsm_type;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [3:0] idx;
    logic [9:0] code;
  } acv_sar_state_type;

endpackage

// ==== rtl/acv_sar_if.sv ====
// Signals between the control logic and the approximation engine.
`timescale 1ns/100ps
interface acv_sar_if;
  logic       start;
  logic       abort;
  logic       tick;
  logic       comp_above;
  logic       busy;
  logic       done;
  logic [9:0] code;

  modport engine (input start, input abort, input tick, input comp_above,
                  output busy, output done, output code);
  modport ctrl (output start, output abort, output tick, output comp_above,
                input busy, input done, input code);
endinterface

// ==== rtl/acv_sar.sv ====
// Ten-bit successive approximation engine, one bit per conversion tick.
`timescale 1ns/100ps
module acv_sar (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  acv_sar_if.engine sar
);

  acv_pkg::acv_sar_state_type s;
  acv_pkg::acv_sar_state_type next_s;

  // Trial code drives the comparator DAC; a done pulse ends the sequence.
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (sar.abort) begin
      next_s.busy = 1'b0;
    end else if (sar.start) begin
      next_s.busy = 1'b1;
      next_s.idx  = 4'h9;
      next_s.code = 10'h200;
    end else if (s.busy && sar.tick) begin
      // Keep the trial bit only when the input lies above it.
      if (!sar.comp_above) begin
        next_s.code[s.idx] = 1'b0;
      end
      if (s.idx == 4'h0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.idx = s.idx - 4'h1;
        next_s.code[s.idx - 4'h1] = 1'b1;
      end
    end
  end

  // State register; the code is kept across reset and abort.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s <= '{busy: 1'b0, done: 1'b0, idx: 4'h0, code: s.code};
    end else begin
      s <= next_s;
    end
  end

  assign sar.busy = s.busy;
  assign sar.done = s.done;
  assign sar.code = s.code;

endmodule // acv_sar

// ==== rtl/acv_ctrl.sv ====
// Converter control: registers, clock selection, sequencing and halt logic.
//
// Functional notes
// (RULE1) Software waits the acquisition interval after a channel change.
// (RULE2) With the internal oscillator, start waits one instruction cycle.
// (RULE3) Completion clears the run flag and loads both result bytes.
// (RULE4) Enabled converter interrupt wakes the halted device on completion.
// (RULE5) Without interrupt, halt powers converter down after finishing.
// (RULE6) Halt with another clock aborts and powers down; power bit stays.
// (RULE7) Reset restores registers and aborts; result bytes keep contents.
// (RULE8) Justify selects 8+2 left or 2+8 right split of the result.
// (RULE9) Setting run flag while powered starts a conversion.
// (RULE10) Completion sets done flag; requests only when enabled.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`include "acv_cfg.svh"
module acv_ctrl (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        halt_mode,
  input  wire logic        comp_above,
  output logic [9:0]       dac_code,
  output logic [2:0]       channel_select,
  output logic             reference_select,
  output logic [7:0]       analog_pin_enable,
  output logic             converter_active,
  output logic             wake_req,
  output logic             irq
);

  typedef struct packed {
    logic [7:0]          ictl;
    logic [7:0]          pflags;
    logic [7:0]          pie;
    logic [7:0]          pinsel;
    logic [7:0]          ctrl;
    logic [7:0]          clksel;
    logic [7:0]          res_hi;
    logic [7:0]          res_lo;
    logic [1:0]          irq_stat;
    logic [1:0]          irq_mask;
    acv_pkg::acv_fsm_type fsm;
    logic [2:0]          delay_cnt;
    logic                halted_off;
    logic [7:0]          rc_cnt;
    logic [5:0]          pre_cnt;
    logic [31:0]         rdata;
  } acv_state_type;

  acv_state_type s;
  acv_state_type next_s;
  acv_sar_if     sar ();

  logic       start_sar;
  logic       abort_sar;
  logic       is_rc;
  logic       conv_tick;
  logic [7:0] idx;
  logic       wr_en;
  logic [7:0] wd;
  logic [1:0] events;

  // Checks that an APB byte address is word-aligned and names an implemented register.
  function automatic logic addr_ok(input logic [11:0] a);
    return (a[1:0] == 2'b00) && (a[11:10] == 2'b00) &&
           ((a[9:2] == `ACV_IDX_ICTL) || (a[9:2] == `ACV_IDX_PFLAGS) ||
            (a[9:2] == `ACV_IDX_RES_HI) || (a[9:2] == `ACV_IDX_CTRL) ||
            (a[9:2] == `ACV_IDX_PIE) || (a[9:2] == `ACV_IDX_PINSEL) ||
            (a[9:2] == `ACV_IDX_RES_LO) || (a[9:2] == `ACV_IDX_CLKSEL) ||
            (a[9:2] == `ACV_IDX_IRQ_STAT) || (a[9:2] == `ACV_IDX_IRQ_MASK));
  endfunction

  // Divider tick for the system-clock conversion rates.
  function automatic logic div_tick(input logic [2:0] sel,
                                    input logic [5:0] cnt);
    logic t;
    t = 1'b0;
    unique case (sel)
      3'b000:  t = (cnt[0] == 1'b1);
      3'b100:  t = (cnt[1:0] == 2'b11);
      3'b001:  t = (cnt[2:0] == 3'b111);
      3'b101:  t = (cnt[3:0] == 4'hf);
      3'b010:  t = (cnt[4:0] == 5'h1f);
      3'b110:  t = (cnt == 6'h3f);
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Splits a ten-bit result into high and low bytes by justification.
  function automatic logic [15:0] justify(input logic       right,
                                          input logic [9:0] r);
    return right ? {6'h00, r[9:8], r[7:0]} : {r[9:2], r[1:0], 6'h00};
  endfunction

  // Read multiplexer for the register bank.
  function automatic logic [7:0] rd_mux(input acv_state_type st,
                                        input logic [7:0]    i);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      `ACV_IDX_ICTL:     v = st.ictl;
      `ACV_IDX_PFLAGS:   v = st.pflags;
      `ACV_IDX_RES_HI:   v = st.res_hi;
      `ACV_IDX_CTRL:     v = st.ctrl;
      `ACV_IDX_PIE:      v = st.pie;
      `ACV_IDX_PINSEL:   v = st.pinsel;
      `ACV_IDX_RES_LO:   v = st.res_lo;
      `ACV_IDX_CLKSEL:   v = st.clksel;
      `ACV_IDX_IRQ_STAT: v = {6'h00, st.irq_stat};
      `ACV_IDX_IRQ_MASK: v = {6'h00, st.irq_mask};
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  // Bus strobes and clock selection.
  assign idx   = paddr[9:2];
  assign wr_en = psel && penable && pwrite && addr_ok(paddr);
  assign wd    = pwdata[7:0];
  assign is_rc = (s.clksel[`ACV_ADCS_LO+1:`ACV_ADCS_LO] == 2'b11);
  // (RULE9) Selected clock paces it.
  assign conv_tick = is_rc ? (s.rc_cnt == 8'(`ACV_RC_CYC - 1))
                           : div_tick(s.clksel[`ACV_ADCS_HI:`ACV_ADCS_LO],
                                      s.pre_cnt);

  // Next-state logic: software writes first, hardware events after them.
  always_comb begin
    next_s    = s;
    start_sar = 1'b0;
    abort_sar = 1'b0;
    events    = 2'b00;
    next_s.pre_cnt = s.pre_cnt + 6'h01;
    next_s.rc_cnt  = (s.rc_cnt == 8'(`ACV_RC_CYC - 1)) ? 8'h00
                                                       : s.rc_cnt + 8'h01;
    // Read data is captured in the setup cycle.
    if (psel && !penable) begin
      next_s.rdata = {24'h000000, rd_mux(s, idx)};
    end
    if (wr_en) begin
      unique case (idx)
        `ACV_IDX_ICTL:     next_s.ictl   = wd;
        `ACV_IDX_PFLAGS:   next_s.pflags = wd & `ACV_MSK_FLAGS;
        `ACV_IDX_RES_HI:   next_s.res_hi = wd;
        `ACV_IDX_CTRL:     next_s.ctrl   = wd & `ACV_MSK_CTRL;
        `ACV_IDX_PIE:      next_s.pie    = wd & `ACV_MSK_FLAGS;
        `ACV_IDX_PINSEL:   next_s.pinsel = wd;
        `ACV_IDX_RES_LO:   next_s.res_lo = wd;
        `ACV_IDX_CLKSEL:   next_s.clksel = wd & `ACV_MSK_CLKSEL;
        `ACV_IDX_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~wd[1:0];
        `ACV_IDX_IRQ_MASK: next_s.irq_mask = wd[1:0];
        default:           next_s.ictl   = s.ictl;
      endcase
    end
    // A run request without power is dropped.
    if (!next_s.ctrl[`ACV_BIT_POWER]) begin
      next_s.ctrl[`ACV_BIT_GO] = 1'b0;
    end
    // (RULE6) Other clock: halt powers off.
    if (halt_mode && !is_rc) begin
      next_s.halted_off = 1'b1;
    end else if (!halt_mode) begin
      next_s.halted_off = 1'b0;
    end
    unique case (s.fsm)
      acv_pkg::ACV_IDLE: begin
        // (RULE9) Run flag starts conversion.
        if (next_s.ctrl[`ACV_BIT_GO] && !next_s.halted_off) begin
          if (is_rc) begin
            // (RULE2) One instruction delay.
            next_s.fsm       = acv_pkg::ACV_DELAY;
            next_s.delay_cnt = 3'(`ACV_INSTR_CYC - 1);
          end else begin
            start_sar  = 1'b1;
            next_s.fsm = acv_pkg::ACV_CONV;
          end
        end
      end
      acv_pkg::ACV_DELAY: begin
        if (!next_s.ctrl[`ACV_BIT_GO] || next_s.halted_off) begin
          next_s.fsm               = acv_pkg::ACV_IDLE;
          next_s.ctrl[`ACV_BIT_GO] = 1'b0;
          events[1]                = 1'b1;
        end else if (s.delay_cnt == 3'h0) begin
          // (RULE2) Start after the delay.
          start_sar  = 1'b1;
          next_s.fsm = acv_pkg::ACV_CONV;
        end else begin
          next_s.delay_cnt = s.delay_cnt - 3'h1;
        end
      end
      acv_pkg::ACV_CONV: begin
        if (!next_s.ctrl[`ACV_BIT_GO] || next_s.halted_off) begin
          // (RULE6) Abort on halt.
          abort_sar                = 1'b1;
          next_s.fsm               = acv_pkg::ACV_IDLE;
          next_s.ctrl[`ACV_BIT_GO] = 1'b0;
          events[1]                = 1'b1;
        end else if (sar.done) begin
          // (RULE3) Clear run flag, load result.
          next_s.fsm               = acv_pkg::ACV_IDLE;
          next_s.ctrl[`ACV_BIT_GO] = 1'b0;
          // (RULE8) Result justification split.
          {next_s.res_hi, next_s.res_lo} =
            justify(s.ctrl[`ACV_BIT_JUSTIFY], sar.code);
          // (RULE10) Done flag set wins.
          next_s.pflags[`ACV_BIT_DONE] = 1'b1;
          events[0]                    = 1'b1;
          // (RULE5) Power down without interrupt.
          if (halt_mode && !s.pie[`ACV_BIT_DONE]) begin
            next_s.halted_off = 1'b1;
          end
        end
      end
      default: begin
        abort_sar  = 1'b1;
        next_s.fsm = acv_pkg::ACV_IDLE;
      end
    endcase
    // Events win over a clear written in the same cycle.
    next_s.irq_stat = next_s.irq_stat | events;
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // (RULE7) Reset values; results kept.
      s <= '{ictl: `ACV_RST_ICTL, pflags: `ACV_RST_PFLAGS,
             pie: `ACV_RST_PIE, pinsel: `ACV_RST_PINSEL,
             ctrl: `ACV_RST_CTRL, clksel: `ACV_RST_CLKSEL,
             res_hi: s.res_hi, res_lo: s.res_lo,
             irq_stat: 2'b00, irq_mask: 2'b00,
             fsm: acv_pkg::ACV_IDLE, delay_cnt: 3'h0,
             halted_off: 1'b0, rc_cnt: 8'h00, pre_cnt: 6'h00,
             rdata: 32'h00000000};
    end else begin
      s <= next_s;
    end
  end

  // Approximation engine hookup; reset also aborts it.
  assign sar.start      = start_sar;
  assign sar.abort      = abort_sar;
  assign sar.tick       = conv_tick && (s.fsm == acv_pkg::ACV_CONV);
  assign sar.comp_above = comp_above;

  acv_sar u_sar (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .sar      (sar.engine)
  );

  // Bus answers: zero wait states, error on unmapped addresses.
  assign pready  = 1'b1;
  assign prdata  = s.rdata;
  assign pslverr = psel && penable && !addr_ok(paddr);

  // Analogue-side controls; the power bit stays set while halted off.
  assign dac_code          = sar.code;
  assign channel_select    = s.ctrl[`ACV_CHS_HI:`ACV_CHS_LO];
  assign reference_select  = s.ctrl[`ACV_BIT_REF];
  assign analog_pin_enable = s.pinsel;
  assign converter_active  = s.ctrl[`ACV_BIT_POWER] && !s.halted_off;

  // (RULE4) Enabled completion wakes device.
  assign wake_req = halt_mode && s.pflags[`ACV_BIT_DONE] &&
                    s.pie[`ACV_BIT_DONE];
  // (RULE10) Gated by enables.
  assign irq = |(s.irq_stat & s.irq_mask);

endmodule // acv_ctrl

// ==== verification/acv_source.sv ====
// Analogue source model at the selected input, seen through the comparator.
`timescale 1ns/100ps
module acv_source (
  input  wire logic [9:0] level,
  input  wire logic [9:0] dac_code,
  output logic            comp_above
);
  // The input sits half a step above level, so the search settles on level.
  assign comp_above = {level, 1'b1} > {dac_code, 1'b0};
endmodule // acv_source

// ==== verification/acv_ctrl_sva.sv ====
// Concurrent checks on the converter control ports.
`timescale 1ns/100ps
`include "acv_cfg.svh"
module acv_ctrl_sva (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        halt_mode,
  input wire logic [9:0]  dac_code,
  input wire logic [2:0]  channel_select,
  input wire logic        reference_select,
  input wire logic [7:0]  analog_pin_enable,
  input wire logic        converter_active,
  input wire logic        wake_req,
  input wire logic        irq
);
  logic       wr;
  logic       wr_ctrl;
  logic       go_wr;
  logic       clk_rc;
  logic [7:0] wr_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Decodes completed writes by register index.
  assign wr      = psel && penable && pwrite;
  assign wr_ctrl = wr && paddr == {2'b00, `ACV_IDX_CTRL, 2'b00};
  assign go_wr   = wr_ctrl && pwdata[1:0] == 2'b11;
  // Remembers the previous cycle's write data and whether the oscillator is chosen.
  always_ff @(posedge core_clk) begin
    wr_q <= pwdata[7:0];
    if (sys_rst) begin
      clk_rc <= 1'b0;
    end else if (wr && paddr == {2'b00, `ACV_IDX_CLKSEL, 2'b00}) begin
      clk_rc <= pwdata[5:4] == 2'b11;
    end
  end
  property p_start;
    go_wr && !clk_rc |-> ##[1:3] dac_code == 10'h200;
  endproperty
  a_start: assert property (p_start)
    else $error("conversion did not start");
  property p_start_rc;
    go_wr && clk_rc |-> ##1 $stable(dac_code) ##[3:7] dac_code == 10'h200;
  endproperty
  a_start_rc: assert property (p_start_rc)
    else $error("oscillator start not delayed");
  property p_reset;
    $fell(sys_rst) |-> !converter_active && channel_select == 3'h0 &&
      !reference_select && analog_pin_enable == 8'hff && !irq && !wake_req;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not at reset state");
  property p_wake;
    wake_req |-> halt_mode;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request outside halt");
  property p_halt_abort;
    halt_mode && !clk_rc |-> ##[0:2] !converter_active;
  endproperty
  a_halt_abort: assert property (p_halt_abort)
    else $error("converter kept running in halt");
  property p_halt_rc;
    $rose(halt_mode) && clk_rc && converter_active |=> converter_active;
  endproperty
  a_halt_rc: assert property (p_halt_rc)
    else $error("oscillator conversion stopped by halt");
  property p_chsel;
    wr_ctrl |=> channel_select == wr_q[4:2] && reference_select == wr_q[6];
  endproperty
  a_chsel: assert property (p_chsel)
    else $error("channel select not updated");
  property p_analog_pin_select;
    wr && paddr == {2'b00, `ACV_IDX_PINSEL, 2'b00} |=>
      analog_pin_enable == wr_q;
  endproperty
  a_analog_pin_select: assert property (p_analog_pin_select)
    else $error("pin select not updated");
endmodule // acv_ctrl_sva
bind acv_ctrl acv_ctrl_sva acv_ctrl_sva_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .halt_mode(halt_mode),
  .dac_code(dac_code), .channel_select(channel_select),
  .reference_select(reference_select), .analog_pin_enable(analog_pin_enable),
  .converter_active(converter_active), .wake_req(wake_req), .irq(irq));

// ==== verification/adc_sleep_reset_control_bench.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`include "acv_cfg.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin \
  n_mismatch++; $display("BAD %0t %s", $time, m); end end
module adc_sleep_reset_control_bench;
  logic        core_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        halt_mode;
  logic        comp_above;
  logic [9:0]  dac_code;
  logic        converter_active;
  logic        wake_req;
  logic        irq;
  logic [9:0]  level;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          checked;
  int          cycles;
  int          wn;
  // Rows: write flag, index, data written, value read back, error.
  logic [25:0] rows [12] = '{
    {1'b0, `ACV_IDX_ICTL, 8'h00, `ACV_RST_ICTL, 1'b0},
    {1'b0, `ACV_IDX_PFLAGS, 8'h00, `ACV_RST_PFLAGS, 1'b0},
    {1'b0, `ACV_IDX_CTRL, 8'h00, `ACV_RST_CTRL, 1'b0},
    {1'b0, `ACV_IDX_PIE, 8'h00, `ACV_RST_PIE, 1'b0},
    {1'b0, `ACV_IDX_PINSEL, 8'h00, `ACV_RST_PINSEL, 1'b0},
    {1'b0, `ACV_IDX_CLKSEL, 8'h00, `ACV_RST_CLKSEL, 1'b0},
    {1'b1, `ACV_IDX_CTRL, 8'hfc, 8'hdc, 1'b0},
    {1'b1, `ACV_IDX_PIE, 8'hff, 8'hc9, 1'b0},
    {1'b1, `ACV_IDX_CLKSEL, 8'hff, 8'h70, 1'b0},
    {1'b1, `ACV_IDX_PINSEL, 8'h5a, 8'h5a, 1'b0},
    {1'b1, `ACV_IDX_RES_HI, 8'ha5, 8'ha5, 1'b0},
    {1'b1, 8'h50, 8'h77, 8'h00, 1'b1}};
  acv_ctrl acv_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .halt_mode(halt_mode), .comp_above(comp_above), .dac_code(dac_code),
    .channel_select(), .reference_select(), .analog_pin_enable(),
    .converter_active(converter_active), .wake_req(wake_req), .irq(irq));
  acv_source acv_source_inst (.level(level), .dac_code(dac_code),
    .comp_above(comp_above));
  // One bus transfer; read data and error are taken at the ready edge.
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, i, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Powers up on a channel, waits for the input to settle, then starts.
  task automatic convert(input logic [7:0] ctl);
    xfer(1'b1, `ACV_IDX_CTRL, ctl);
    repeat (800) @(posedge core_clk);
    xfer(1'b1, `ACV_IDX_CTRL, ctl | 8'h02);
  endtask
  // Polls the run flag until it clears.
  task automatic wait_idle;
    wn = 0;
    do begin
      xfer(1'b0, `ACV_IDX_CTRL, 8'h00);
      wn++;
    end while (rd[1] !== 1'b0 && wn < 1000);
  endtask
  // Reads both result bytes and compares them with the split of v.
  task automatic chk_res(input logic [9:0] v, input logic right);
    xfer(1'b0, `ACV_IDX_RES_HI, 8'h00);
    `CHK(rd[7:0], right ? {6'h00, v[9:8]} : v[9:2], "high byte")
    xfer(1'b0, `ACV_IDX_RES_LO, 8'h00);
    `CHK(rd[7:0], right ? v[7:0] : {v[1:0], 6'h00}, "low byte")
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Clock generator.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Cuts a hang short.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  // Main sequence.
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; halt_mode = 1'b0;
    level = 10'h000; n_mismatch = 0; checked = 0; cycles = 0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][25]) xfer(1'b1, rows[i][24:17], rows[i][16:9]);
      xfer(1'b0, rows[i][24:17], 8'h00);
      `CHK(rd[7:0], rows[i][8:1], "register value")
      `CHK(err, rows[i][0], "error response")
    end
    xfer(1'b1, `ACV_IDX_CLKSEL, 8'h00);
    xfer(1'b1, `ACV_IDX_PIE, 8'h00);
    for (int j = 0; j < 2; j++) begin
      level <= j[0] ? 10'h13a : 10'h2d7;
      convert({j[0], 7'h0d});
      wait_idle;
      `CHK(rd[1], 1'b0, "run flag")
      chk_res(level, j[0]);
      xfer(1'b0, `ACV_IDX_PFLAGS, 8'h00);
      `CHK(rd[7:0], 8'h40, "done flag")
      `CHK(irq, 1'b0, "masked irq")
      xfer(1'b1, `ACV_IDX_PFLAGS, 8'h00);
    end
    xfer(1'b1, `ACV_IDX_IRQ_MASK, 8'h01);
    @(posedge core_clk);
    `CHK(irq, 1'b1, "irq raised")
    xfer(1'b1, `ACV_IDX_IRQ_STAT, 8'h01);
    @(posedge core_clk);
    `CHK(irq, 1'b0, "irq cleared")
    xfer(1'b1, `ACV_IDX_CLKSEL, 8'h30);
    xfer(1'b1, `ACV_IDX_PIE, 8'h40);
    level <= 10'h0f1;
    convert(8'h01);
    halt_mode <= 1'b1;
    wn = 0;
    while (wake_req !== 1'b1 && wn < 2500) begin
      @(posedge core_clk);
      wn++;
    end
    `CHK(wake_req, 1'b1, "no wake")
    halt_mode <= 1'b0;
    chk_res(10'h0f1, 1'b0);
    xfer(1'b1, `ACV_IDX_PFLAGS, 8'h00);
    xfer(1'b1, `ACV_IDX_PIE, 8'h00);
    level <= 10'h3c5;
    convert(8'h01);
    halt_mode <= 1'b1;
    wait_idle;
    `CHK(rd[0], 1'b1, "power bit")
    @(posedge core_clk);
    `CHK(converter_active, 1'b0, "still powered")
    `CHK(wake_req, 1'b0, "wake without enable")
    halt_mode <= 1'b0;
    xfer(1'b1, `ACV_IDX_CLKSEL, 8'h60);
    level <= 10'h055;
    convert(8'h01);
    halt_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(converter_active, 1'b0, "halt not aborting")
    xfer(1'b0, `ACV_IDX_CTRL, 8'h00);
    `CHK(rd[0], 1'b1, "power bit lost")
    xfer(1'b0, `ACV_IDX_IRQ_STAT, 8'h00);
    `CHK(rd[7:0], 8'h03, "abort event")
    halt_mode <= 1'b0;
    xfer(1'b1, `ACV_IDX_CTRL, 8'h00);
    chk_res(10'h3c5, 1'b0);
    convert(8'h01);
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    xfer(1'b0, `ACV_IDX_CTRL, 8'h00);
    `CHK(rd[7:0], 8'h00, "control after reset")
    `CHK(converter_active, 1'b0, "active after reset")
    chk_res(10'h3c5, 1'b0);
    wrap_up;
  end
endmodule // adc_sleep_reset_control_bench
